/* File: include/aifp_regs.vh */
// register map, reset values, field positions and filter codes of the feature stage
`ifndef AIFP_REGS_VH
`define AIFP_REGS_VH
`define AIFP_ADR_MFR_OFS 6'h13
`define AIFP_ADR_MFR_GAIN 6'h14
`define AIFP_ADR_UPPER 6'h15
`define AIFP_ADR_LOWER 6'h16
`define AIFP_ADR_CODE 6'h1F
`define AIFP_ADR_CFG 6'h20
`define AIFP_ADR_UOFS 6'h21
`define AIFP_ADR_UGAIN 6'h22
`define AIFP_ADR_LIM1 6'h23
`define AIFP_ADR_LIM2 6'h24
`define AIFP_ADR_FSEL 6'h25
`define AIFP_RST_MFR_OFS 16'h8000
`define AIFP_RST_MFR_GAIN 16'h4004
`define AIFP_RST_UPPER 16'h0FFF
`define AIFP_RST_LOWER 16'h0000
`define AIFP_RST_CFG 16'h1106
`define AIFP_RST_UOFS 16'h0000
`define AIFP_RST_UGAIN 16'h0100
`define AIFP_RST_LIM 16'h0000
`define AIFP_RST_FSEL 16'h0000
`define AIFP_UNLOCK_WORD 16'h1235
`define AIFP_CFG_USER 0
`define AIFP_CFG_MFR 1
`define AIFP_CFG_WDOG 2
`define AIFP_CFG_SGNMAG 3
`define AIFP_CFG_TAGGED 4
`define AIFP_CFG_RANGE 8
`define AIFP_CFG_LIM1 9
`define AIFP_CFG_LIM2 10
`define AIFP_CFG_FILT 11
`define AIFP_MFR_SHIFT 4'hA
`define AIFP_USER_SHIFT 4'h8
`define AIFP_CTL_REG 7
`define AIFP_CTL_WR 6
`define AIFP_FSEL_FIR2 16'h0000
`define AIFP_FSEL_IIR_LO 16'h0100
`define AIFP_FSEL_IIR_HI 16'h0700
`define AIFP_FSEL_N50 16'h1000
`define AIFP_FSEL_N60 16'h2000
`define AIFP_LIM_OFF 2'h0
`define AIFP_LIM_BELOW 2'h1
`define AIFP_LIM_ABOVE 2'h2
`define AIFP_LIM_EQUAL 2'h3
`define AIFP_WDOG_MS 100
`define AIFP_CLK_MHZ 125
`endif

/* File: src/aifp_core.v */
// analog input feature stage: register set, filter, scaling, range, limits, output format
// Behaviour
// - feature configuration resets to 0x1106.
// - bit 0 enables user scaling, bit 1 enables manufacturer scaling.
// - bit 2 enables the watchdog, on by default.
// - bit 3 gives sign-magnitude output, minus one reads 0x8001.
// - bit 4 selects the status-tagged output format, off by default.
// - tagged format: bit 2 zero, bit 1 error, bit 0 overflow.
// - tagged format: value in bits 15 to 3, bit 15 the sign.
// - overflow set outside the range; inside it bits 2 and 0 clear, bit 1 still shows the error.
// - bit 8 flags out-of-range values and clamps them to the limit.
// - bit 9 compares each output with the first threshold.
// - bit 10 compares each output with the second threshold.
// - bit 11 enables the filter, whose type comes from the filter select.
// - user offset is a signed 16-bit term added in user scaling.
// - user gain is signed 16-bit, weight two to the minus eight.
// - filter select resets to zero, the two-tap FIR filter.
// - codes 0x0100 to 0x0700 pick first-order IIR filters, falling corner.
// - code 0x1000 averages sixteen samples, for 50 Hz rejection.
// - code 0x2000 averages sixteen samples, for 60 Hz rejection.
// - any other filter code bypasses the filter.
// - notch timing follows channel 0; conflicting notch on channel 1 cannot run.
// - limit status: 00 off, 01 below, 10 above, 11 equal.
// - user registers are writable only while the unlock word 0x1235 is held.
`timescale 1ns/1ns
`include "aifp_regs.vh"
module aifp_core #(
	parameter IS_CH0 = 1,
	parameter WDOG_CYCLES = `AIFP_WDOG_MS * `AIFP_CLK_MHZ * 1000
) (
	input wire i_clk_sys,
	input wire i_rst_n,
	input wire i_reg_req,
	input wire [7:0] i_ctrl_byte,
	input wire [15:0] i_reg_wdata,
	output reg o_reg_ack,
	output reg [7:0] o_reg_status,
	output reg [15:0] o_reg_rdata,
	input wire i_smp_valid,
	input wire [15:0] i_smp_data,
	input wire [15:0] i_ch0_fsel,
	output wire [15:0] o_fsel,
	input wire i_host_alive,
	output reg o_out_valid,
	output reg [15:0] o_out_data,
	output reg [7:0] o_out_status,
	output reg o_wdog_trip
);
	reg [15:0] mfr_ofs_q;
	reg [15:0] mfr_gain_q;
	reg [15:0] upper_range_limit_q;
	reg [15:0] lower_range_limit_q;
	reg [15:0] code_q;
	reg [15:0] operation_feature_config_q;
	reg [15:0] user_line_offset_q;
	reg [15:0] user_line_gain_q;
	reg [15:0] first_threshold_q;
	reg [15:0] second_threshold_q;
	reg [15:0] filter_select_q;
	reg [31:0] wdog_cnt_q;

	wire [15:0] cfg = operation_feature_config_q;
	wire unlocked = (code_q == `AIFP_UNLOCK_WORD);
	wire [5:0] adr = i_ctrl_byte[5:0];
	wire is_reg = i_reg_req && i_ctrl_byte[`AIFP_CTL_REG];
	wire do_wr = is_reg && i_ctrl_byte[`AIFP_CTL_WR];

	function signed [15:0] sat16;
		input signed [33:0] v;
		begin
			if (v > 34'sh0000_7FFF)
				sat16 = 16'sh7FFF;
			else if (v < -34'sh0000_8000)
				sat16 = -16'sh8000;
			else
				sat16 = v[15:0];
		end
	endfunction

	// straight line y = off + (x * gain) >> shift, saturated to 16 bits
	function signed [15:0] line16;
		input signed [15:0] x;
		input signed [15:0] gain;
		input signed [15:0] off;
		input [3:0] sh;
		reg signed [33:0] p;
		begin
			p = x * gain;
			line16 = sat16((p >>> sh) + off);
		end
	endfunction

	function [1:0] cmp_code;
		input signed [15:0] v;
		input signed [15:0] lim;
		begin
			if (v == lim)
				cmp_code = `AIFP_LIM_EQUAL;
			else if (v > lim)
				cmp_code = `AIFP_LIM_ABOVE;
			else
				cmp_code = `AIFP_LIM_BELOW;
		end
	endfunction

	// register access; the unlock word itself is always writable
	always @(posedge i_clk_sys) begin
		if (!i_rst_n) begin
			mfr_ofs_q <= `AIFP_RST_MFR_OFS;
			mfr_gain_q <= `AIFP_RST_MFR_GAIN;
			upper_range_limit_q <= `AIFP_RST_UPPER;
			lower_range_limit_q <= `AIFP_RST_LOWER;
			code_q <= 16'h0000;
			operation_feature_config_q <= `AIFP_RST_CFG;
			user_line_offset_q <= `AIFP_RST_UOFS;
			user_line_gain_q <= `AIFP_RST_UGAIN;
			first_threshold_q <= `AIFP_RST_LIM;
			second_threshold_q <= `AIFP_RST_LIM;
			filter_select_q <= `AIFP_RST_FSEL;
		end else if (do_wr) begin
			if (adr == `AIFP_ADR_CODE)
				code_q <= i_reg_wdata;
			else if (unlocked) begin
				case (adr)
				`AIFP_ADR_MFR_OFS: mfr_ofs_q <= i_reg_wdata;
				`AIFP_ADR_MFR_GAIN: mfr_gain_q <= i_reg_wdata;
				`AIFP_ADR_UPPER: upper_range_limit_q <= i_reg_wdata;
				`AIFP_ADR_LOWER: lower_range_limit_q <= i_reg_wdata;
				`AIFP_ADR_CFG: operation_feature_config_q <= i_reg_wdata;
				`AIFP_ADR_UOFS: user_line_offset_q <= i_reg_wdata;
				`AIFP_ADR_UGAIN: user_line_gain_q <= i_reg_wdata;
				`AIFP_ADR_LIM1: first_threshold_q <= i_reg_wdata;
				`AIFP_ADR_LIM2: second_threshold_q <= i_reg_wdata;
				`AIFP_ADR_FSEL: filter_select_q <= i_reg_wdata;
				default: code_q <= code_q;
				endcase
			end
		end
	end

	reg [15:0] rd_mux;
	always @* begin
		case (adr)
		`AIFP_ADR_MFR_OFS: rd_mux = mfr_ofs_q;
		`AIFP_ADR_MFR_GAIN: rd_mux = mfr_gain_q;
		`AIFP_ADR_UPPER: rd_mux = upper_range_limit_q;
		`AIFP_ADR_LOWER: rd_mux = lower_range_limit_q;
		`AIFP_ADR_CODE: rd_mux = unlocked ? code_q : 16'h0000;
		`AIFP_ADR_CFG: rd_mux = operation_feature_config_q;
		`AIFP_ADR_UOFS: rd_mux = user_line_offset_q;
		`AIFP_ADR_UGAIN: rd_mux = user_line_gain_q;
		`AIFP_ADR_LIM1: rd_mux = first_threshold_q;
		`AIFP_ADR_LIM2: rd_mux = second_threshold_q;
		`AIFP_ADR_FSEL: rd_mux = filter_select_q;
		default: rd_mux = 16'h0000;
		endcase
	end

	// the acknowledge echoes the control byte; a write answers with zero data
	always @(posedge i_clk_sys) begin
		if (!i_rst_n) begin
			o_reg_ack <= 1'b0;
			o_reg_status <= 8'h00;
			o_reg_rdata <= 16'h0000;
		end else begin
			o_reg_ack <= is_reg;
			if (is_reg) begin
				o_reg_status <= i_ctrl_byte;
				o_reg_rdata <= do_wr ? 16'h0000 : rd_mux;
			end
		end
	end

	// watchdog: host silence longer than the timeout raises the error flag
	always @(posedge i_clk_sys) begin
		if (!i_rst_n || !cfg[`AIFP_CFG_WDOG] || i_host_alive || i_reg_req) begin
			wdog_cnt_q <= 32'h00000000;
			o_wdog_trip <= 1'b0;
		end else if (wdog_cnt_q >= WDOG_CYCLES - 1) begin
			o_wdog_trip <= 1'b1;
		end else begin
			wdog_cnt_q <= wdog_cnt_q + 32'h00000001;
		end
	end

	// both notch codes share channel 0's sample timer, so channel 1 may only
	// run the notch that channel 0 also runs (or any notch while channel 0 has none)
	wire own_notch = (filter_select_q == `AIFP_FSEL_N50)
		|| (filter_select_q == `AIFP_FSEL_N60);
	wire ch0_notch = (i_ch0_fsel == `AIFP_FSEL_N50) || (i_ch0_fsel == `AIFP_FSEL_N60);
	wire notch_clash = (IS_CH0 == 0) && own_notch && ch0_notch
		&& (i_ch0_fsel != filter_select_q);
	assign o_fsel = filter_select_q;

	wire flt_valid;
	wire [15:0] flt_data;
	aifp_filter u_filter (
		.i_clk_sys(i_clk_sys),
		.i_rst_n(i_rst_n),
		.i_en(cfg[`AIFP_CFG_FILT] && !notch_clash),
		.i_code(filter_select_q),
		.i_valid(i_smp_valid),
		.i_data(i_smp_data),
		.o_valid(flt_valid),
		.o_data(flt_data)
	);

	// scaling chain after the filter
	wire signed [15:0] mfr_y = cfg[`AIFP_CFG_MFR] ? line16(flt_data, mfr_gain_q, mfr_ofs_q,
		`AIFP_MFR_SHIFT) : flt_data;
	wire signed [15:0] user_gain_term = user_line_gain_q;
	wire signed [15:0] usr_y = cfg[`AIFP_CFG_USER] ? line16(mfr_y, user_gain_term,
		user_line_offset_q, `AIFP_USER_SHIFT) : mfr_y;

	wire over = cfg[`AIFP_CFG_RANGE] && (usr_y > $signed(upper_range_limit_q));
	wire under = cfg[`AIFP_CFG_RANGE] && (usr_y < $signed(lower_range_limit_q));
	wire signed [15:0] clamp_y = over ? upper_range_limit_q :
		(under ? lower_range_limit_q : usr_y);
	wire [1:0] lim1 = cfg[`AIFP_CFG_LIM1] ? cmp_code(clamp_y, first_threshold_q)
		: `AIFP_LIM_OFF;
	wire [1:0] lim2 = cfg[`AIFP_CFG_LIM2] ? cmp_code(clamp_y, second_threshold_q)
		: `AIFP_LIM_OFF;

	// minus full scale has no magnitude in 15 bits, so it saturates
	wire [15:0] neg_y = 16'h0000 - clamp_y;
	wire [15:0] sm_y = !clamp_y[15] ? clamp_y :
		(clamp_y == 16'h8000 ? 16'hFFFF : {1'b1, neg_y[14:0]});
	wire [15:0] num_y = cfg[`AIFP_CFG_SGNMAG] ? sm_y : clamp_y;
	// tagged format: overflow means the range clamp acted, error is the watchdog
	wire [15:0] fmt_y = cfg[`AIFP_CFG_TAGGED] ?
		{num_y[15:3], 1'b0, o_wdog_trip, over | under} : num_y;

	always @(posedge i_clk_sys) begin
		if (!i_rst_n) begin
			o_out_valid <= 1'b0;
			o_out_data <= 16'h0000;
			o_out_status <= 8'h00;
		end else begin
			o_out_valid <= flt_valid;
			o_out_status[6] <= o_wdog_trip;
			if (flt_valid) begin
				o_out_data <= fmt_y;
				o_out_status[5:0] <= {lim2, lim1, over, under};
			end
		end
	end
endmodule

/* File: src/aifp_filter.v */
// selectable input filter: two-tap FIR, first-order IIR, sixteen-value average, bypass
`timescale 1ns/1ns
`include "aifp_regs.vh"
module aifp_filter (
	input wire i_clk_sys,
	input wire i_rst_n,
	input wire i_en,
	input wire [15:0] i_code,
	input wire i_valid,
	input wire [15:0] i_data,
	output reg o_valid,
	output reg [15:0] o_data
);
	localparam M_BYP = 2'h0;
	localparam M_FIR2 = 2'h1;
	localparam M_IIR = 2'h2;
	localparam M_AVG = 2'h3;

	function [1:0] mode_of;
		input en;
		input [15:0] c;
		begin
			if (!en)
				mode_of = M_BYP;
			else if (c == `AIFP_FSEL_FIR2)
				mode_of = M_FIR2;
			else if (c >= `AIFP_FSEL_IIR_LO && c <= `AIFP_FSEL_IIR_HI && c[7:0] == 8'h00)
				mode_of = M_IIR;
			else if (c == `AIFP_FSEL_N50 || c == `AIFP_FSEL_N60)
				mode_of = M_AVG;
			else
				mode_of = M_BYP;
		end
	endfunction

	wire [1:0] mode = mode_of(i_en, i_code);
	wire [2:0] iir_k = i_code[10:8];
	reg [1:0] mode_q;
	reg [15:0] code_seen_q;
	reg [15:0] prev_q;
	reg signed [23:0] iir_q;
	reg [15:0] hist_q [0:15];
	reg [3:0] idx_q;
	reg signed [19:0] sum_q;
	integer i;

	// higher codes give a lower corner: the IIR step shrinks by one bit per code
	wire signed [23:0] x_fix = {i_data, 8'h00};
	wire signed [23:0] iir_d = iir_q + ((x_fix - iir_q) >>> iir_k);
	wire signed [19:0] sum_d = sum_q + {{4{i_data[15]}}, i_data}
		- {{4{hist_q[idx_q][15]}}, hist_q[idx_q]};
	wire signed [16:0] fir_sum = {i_data[15], i_data} + {prev_q[15], prev_q};

	// a mode or code change restarts history so stale state of another filter never leaks out
	always @(posedge i_clk_sys) begin
		if (!i_rst_n || mode != mode_q || i_code != code_seen_q) begin
			mode_q <= mode;
			code_seen_q <= i_code;
			prev_q <= 16'h0000;
			iir_q <= 24'h000000;
			idx_q <= 4'h0;
			sum_q <= 20'h00000;
			o_valid <= 1'b0;
			o_data <= 16'h0000;
			for (i = 0; i < 16; i = i + 1)
				hist_q[i] <= 16'h0000;
		end else begin
			o_valid <= i_valid;
			if (i_valid) begin
				prev_q <= i_data;
				case (mode_q)
				M_FIR2: begin
					o_data <= fir_sum[16:1];
				end
				M_IIR: begin
					iir_q <= iir_d;
					o_data <= iir_d[23:8];
				end
				M_AVG: begin
					hist_q[idx_q] <= i_data;
					idx_q <= idx_q + 4'h1;
					sum_q <= sum_d;
					o_data <= sum_d[19:4];
				end
				default: begin
					o_data <= i_data;
				end
				endcase
			end
		end
	end
endmodule

/* File: test/aifp_core_checker.sv */
// concurrent checks on the ports of the feature stage
`timescale 1ns/1ns
module aifp_core_checker (
	input wire i_clk_sys,
	input wire i_rst_n,
	input wire i_reg_req,
	input wire [7:0] i_ctrl_byte,
	input wire o_reg_ack,
	input wire [7:0] o_reg_status,
	input wire [15:0] o_reg_rdata,
	input wire i_smp_valid,
	input wire o_out_valid,
	input wire [15:0] o_out_data,
	input wire [7:0] o_out_status,
	input wire o_wdog_trip
);
	default clocking cb @(posedge i_clk_sys); endclocking
	default disable iff (!i_rst_n);
	property p_ack; i_reg_req && i_ctrl_byte[7] |=> o_reg_ack; endproperty
	a_ack: assert property (p_ack) else $error("request not acknowledged");
	property p_noack; !(i_reg_req && i_ctrl_byte[7]) |=> !o_reg_ack; endproperty
	a_noack: assert property (p_noack) else $error("acknowledge without request");
	property p_echo; i_reg_req && i_ctrl_byte[7] |=> o_reg_status == $past(i_ctrl_byte); endproperty
	a_echo: assert property (p_echo) else $error("status byte not echoed");
	property p_code; i_reg_req && i_ctrl_byte == 8'h9F |=>
		o_reg_rdata == 16'h0000 || o_reg_rdata == 16'h1235; endproperty
	a_code: assert property (p_code) else $error("unlock register read wrong");
	property p_lat; i_smp_valid |-> ##2 o_out_valid; endproperty
	a_lat: assert property (p_lat) else $error("output word late or missing");
	property p_hold; !o_out_valid |-> $stable(o_out_data) && $stable(o_out_status[5:0]);
	endproperty
	a_hold: assert property (p_hold) else $error("output changed between samples");
	property p_excl; o_out_valid |-> !(o_out_status[1] && o_out_status[0]); endproperty
	a_excl: assert property (p_excl) else $error("over and under both set");
	property p_msb; o_out_status[7] == 1'b0; endproperty
	a_msb: assert property (p_msb) else $error("status bit 7 set");
	property p_err; o_wdog_trip |=> o_out_status[6]; endproperty
	a_err: assert property (p_err) else $error("error bit not following watchdog");
endmodule
bind aifp_core aifp_core_checker u_aifp_core_checker (.i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n),
	.i_reg_req(i_reg_req), .i_ctrl_byte(i_ctrl_byte), .o_reg_ack(o_reg_ack),
	.o_reg_status(o_reg_status), .o_reg_rdata(o_reg_rdata), .i_smp_valid(i_smp_valid),
	.o_out_valid(o_out_valid), .o_out_data(o_out_data), .o_out_status(o_out_status),
	.o_wdog_trip(o_wdog_trip));

/* File: test/aifp_host_mon.sv */
// far-side model: controller latching each processed word with its status
`timescale 1ns/1ns
module aifp_host_mon (
	input wire logic i_clk_sys,
	input wire logic i_out_valid,
	input wire logic [15:0] i_out_data,
	input wire logic [7:0] i_out_status,
	output logic [15:0] o_last_data,
	output logic [7:0] o_last_status
);
	// held data between pulses is not trusted, only words marked valid are taken
	always @(posedge i_clk_sys) begin
		if (i_out_valid) begin
			o_last_data <= i_out_data;
			o_last_status <= i_out_status;
		end
	end
endmodule

/* File: test/tb_top.sv */
// self-checking bench for the analog input feature stage
`timescale 1ns/1ns
`define CHK(g, e) chk(g, e)
module tb_top;
	logic clk = 0, rst_n = 0, req = 0, smp = 0, alive = 1;
	logic [7:0] ctrl = 8'h00;
	logic [15:0] wd = 16'h0000, sd = 16'h0000, ch0 = 16'h0000;
	logic ack, ov, trip;
	logic [7:0] rs, ost, m_stat;
	logic [15:0] rd, od, fsel, m_data;
	logic [7:0] lim_st [3] = '{8'h14, 8'h2C, 8'h28};
	int n_mismatch = 0, cmp_count = 0, cyc = 0, k;
	always #4 clk = ~clk;
	aifp_core #(.IS_CH0(0), .WDOG_CYCLES(20)) u_aifp_core (.i_clk_sys(clk), .i_rst_n(rst_n),
		.i_reg_req(req), .i_ctrl_byte(ctrl), .i_reg_wdata(wd), .o_reg_ack(ack),
		.o_reg_status(rs), .o_reg_rdata(rd), .i_smp_valid(smp), .i_smp_data(sd),
		.i_ch0_fsel(ch0), .o_fsel(fsel), .i_host_alive(alive), .o_out_valid(ov),
		.o_out_data(od), .o_out_status(ost), .o_wdog_trip(trip));
	aifp_host_mon u_aifp_host_mon (.i_clk_sys(clk), .i_out_valid(ov), .i_out_data(od),
		.i_out_status(ost), .o_last_data(m_data), .o_last_status(m_stat));
	task chk(input logic [15:0] g, input logic [15:0] e);
		cmp_count++;
		if (g !== e) begin
			n_mismatch++;
			$display("BAD %0t got %h exp %h", $time, g, e);
		end
	endtask
	task acc(input logic [7:0] c, input logic [15:0] w);
		@(negedge clk);
		req = 1;
		ctrl = c;
		wd = w;
		@(negedge clk);
		req = 0;
		for (k = 0; k < 4 && ack !== 1'b1; k++) @(negedge clk);
	endtask
	task wr(input logic [5:0] a, input logic [15:0] w);
		acc({2'b11, a}, w);
	endtask
	task rdc(input logic [5:0] a, input logic [15:0] e);
		acc({2'b10, a}, 16'h0000);
		`CHK(rd, e);
	endtask
	// waits one more edge so the far-side model has latched the word
	task smpc(input logic [15:0] x, input logic [15:0] e);
		@(negedge clk);
		smp = 1;
		sd = x;
		@(negedge clk);
		smp = 0;
		for (k = 0; k < 5 && ov !== 1'b1; k++) @(negedge clk);
		@(negedge clk);
		`CHK(m_data, e);
	endtask
	task wrap_up;
		$display("mismatches %0d comparisons %0d", n_mismatch, cmp_count);
		if (n_mismatch == 0 && cmp_count > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	always @(posedge clk) begin
		cyc++;
		if (cyc == 5000) begin
			n_mismatch++;
			wrap_up();
		end
	end
	initial begin
		repeat (4) @(negedge clk);
		rst_n = 1;
		rdc(6'h20, 16'h1106);
		rdc(6'h25, 16'h0000);
		rdc(6'h22, 16'h0100);
		rdc(6'h1F, 16'h0000);
		wr(6'h20, 16'h0000);
		rdc(6'h20, 16'h1106);
		wr(6'h1F, 16'h1235);
		rdc(6'h1F, 16'h1235);
		rdc(6'h3A, 16'h0000);
		wr(6'h20, 16'hF0E0);
		rdc(6'h20, 16'hF0E0);
		smpc(16'h0007, 16'h0007);
		wr(6'h20, 16'h0008);
		smpc(16'hFFFF, 16'h8001);
		wr(6'h13, 16'h0000);
		wr(6'h14, 16'h0800);
		wr(6'h21, 16'h000A);
		wr(6'h22, 16'h0200);
		wr(6'h20, 16'h0002);
		smpc(16'd100, 16'd200);
		wr(6'h20, 16'h0001);
		smpc(16'd100, 16'd210);
		wr(6'h20, 16'h0003);
		smpc(16'd100, 16'd410);
		wr(6'h20, 16'h0100);
		smpc(16'h2000, 16'h0FFF);
		`CHK({8'h00, m_stat}, 16'h0002);
		smpc(16'hFFFB, 16'h0000);
		`CHK({8'h00, m_stat}, 16'h0001);
		wr(6'h21, 16'h0000);
		wr(6'h22, 16'h0800);
		wr(6'h20, 16'h0111);
		smpc(16'h2000, 16'h0FF9);
		smpc(16'h0100, 16'h0800);
		wr(6'h23, 16'd50);
		wr(6'h24, 16'd45);
		wr(6'h20, 16'h0600);
		for (int i = 0; i < 3; i++) begin
			smpc(16'd40 + 16'd10 * i[15:0], 16'd40 + 16'd10 * i[15:0]);
			`CHK({8'h00, m_stat}, {8'h00, lim_st[i]});
		end
		wr(6'h20, 16'h0000);
		smpc(16'd50, 16'd50);
		`CHK({8'h00, m_stat}, 16'h0000);
		wr(6'h20, 16'h0800);
		smpc(16'd10, 16'd5);
		smpc(16'd20, 16'd15);
		for (int i = 1; i < 8; i++) begin
			wr(6'h25, {4'h0, i[3:0], 8'h00});
			smpc(16'h1000, 16'h1000 >> i);
		end
		wr(6'h25, 16'h1000);
		smpc(16'd16, 16'd1);
		smpc(16'd16, 16'd2);
		wr(6'h25, 16'h2000);
		smpc(16'd32, 16'd2);
		ch0 = 16'h1000;
		smpc(16'd32, 16'd32);
		`CHK(fsel, 16'h2000);
		wr(6'h25, 16'h0150);
		smpc(16'd33, 16'd33);
		wr(6'h20, 16'h0014);
		alive = 0;
		repeat (40) @(negedge clk);
		`CHK({15'h0000, trip}, 16'h0001);
		`CHK({15'h0000, ost[6]}, 16'h0001);
		smpc(16'h0100, 16'h0102);
		alive = 1;
		@(negedge clk);
		`CHK({15'h0000, trip}, 16'h0000);
		wrap_up();
	end
endmodule
